// ### timer8_waveform_output_control.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module timer8_waveform_output_control #(
  parameter int ADDR_W = timer8_pkg::ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] countValue,
  output logic chanAWaveOut,
  output logic chanAPinOverride,
  output logic chanBWaveOut,
  output logic chanBPinOverride
);
  typedef struct packed {
    logic [1:0] chanAOutputMode;
    logic [1:0] chanBOutputMode;
    logic [1:0] waveModeLowBits;
    logic waveModeHighBit;
    logic [2:0] clockSelectField;
    logic [7:0] count;
    logic up;
    logic [7:0] cmpABuf;
    logic [7:0] cmpBBuf;
    logic [7:0] cmpAAct;
    logic [7:0] cmpBAct;
    logic blockMatch;
    logic overflowFlag;
    logic cmpAFlag;
    logic cmpBFlag;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } top_state_t;
  top_state_t s_reg;
  top_state_t s_next;

  logic [2:0] waveModeField;
  timer8_pkg::wave_class_t waveClass;
  logic topIsCmpA;
  logic [7:0] topVal;
  logic tick;
  logic atTop;
  logic matchA;
  logic matchB;
  logic bottomEvt;
  logic topEvt;
  logic ovfEvt;
  logic access;
  logic mapped;
  logic wrCtrlA;
  logic wrCtrlB;
  logic wrCount;
  logic wrCmpA;
  logic wrCmpB;
  logic wrFlags;
  logic [31:0] readMux;
  logic [7:0] addr8;

  // mode decode
  always_comb begin
    waveModeField = {s_reg.waveModeHighBit, s_reg.waveModeLowBits};
    unique case (waveModeField)
      timer8_pkg::WM_PHASE_MAX, timer8_pkg::WM_PHASE_CMPA: waveClass = timer8_pkg::CLS_PHASE;
      timer8_pkg::WM_FAST_MAX, timer8_pkg::WM_FAST_CMPA: waveClass = timer8_pkg::CLS_FAST;
      default: waveClass = timer8_pkg::CLS_NONPWM; // reserved codes count as normal
    endcase
    topIsCmpA = (waveModeField == timer8_pkg::WM_CTC) ||
                (waveModeField == timer8_pkg::WM_PHASE_CMPA) ||
                (waveModeField == timer8_pkg::WM_FAST_CMPA);
    topVal = topIsCmpA ? s_reg.cmpAAct : timer8_pkg::COUNT_MAX;
  end

  // timer events
  always_comb begin
    tick = (s_reg.clockSelectField != timer8_pkg::CS_STOPPED);
    atTop = (s_reg.count == topVal);
    matchA = tick && !s_reg.blockMatch && (s_reg.count == s_reg.cmpAAct);
    matchB = tick && !s_reg.blockMatch && (s_reg.count == s_reg.cmpBAct);
    bottomEvt = tick && atTop && (waveClass == timer8_pkg::CLS_FAST);
    topEvt = tick && atTop && s_reg.up && (waveClass == timer8_pkg::CLS_PHASE);
    if (waveClass == timer8_pkg::CLS_PHASE) begin
      ovfEvt = tick && !s_reg.up && (s_reg.count == timer8_pkg::COUNT_BOTTOM);
    end else if (waveModeField == timer8_pkg::WM_FAST_CMPA) begin
      ovfEvt = tick && atTop;
    end else begin
      ovfEvt = tick && (s_reg.count == timer8_pkg::COUNT_MAX);
    end
  end

  // bus decode
  always_comb begin
    addr8 = paddr[7:0];
    access = psel && penable && s_reg.ready;
    mapped = (addr8 == timer8_pkg::ADDR_CTRL_A) || (addr8 == timer8_pkg::ADDR_CTRL_B) ||
             (addr8 == timer8_pkg::ADDR_COUNT) || (addr8 == timer8_pkg::ADDR_CMP_A) ||
             (addr8 == timer8_pkg::ADDR_CMP_B) || (addr8 == timer8_pkg::ADDR_FLAGS);
    wrCtrlA = access && pwrite && (addr8 == timer8_pkg::ADDR_CTRL_A);
    wrCtrlB = access && pwrite && (addr8 == timer8_pkg::ADDR_CTRL_B);
    wrCount = access && pwrite && (addr8 == timer8_pkg::ADDR_COUNT);
    wrCmpA = access && pwrite && (addr8 == timer8_pkg::ADDR_CMP_A);
    wrCmpB = access && pwrite && (addr8 == timer8_pkg::ADDR_CMP_B);
    wrFlags = access && pwrite && (addr8 == timer8_pkg::ADDR_FLAGS);
    readMux = '0;
    unique case (addr8)
      timer8_pkg::ADDR_CTRL_A: begin
        readMux[timer8_pkg::CA_OUT_A_LSB +: 2] = s_reg.chanAOutputMode;
        readMux[timer8_pkg::CA_OUT_B_LSB +: 2] = s_reg.chanBOutputMode;
        readMux[timer8_pkg::CA_WAVE_LSB +: 2] = s_reg.waveModeLowBits; // bits 3:2 zero
      end
      timer8_pkg::ADDR_CTRL_B: begin
        readMux[timer8_pkg::CB_HIGH_BIT] = s_reg.waveModeHighBit;
        readMux[timer8_pkg::CB_CLK_LSB +: 3] = s_reg.clockSelectField;
      end
      timer8_pkg::ADDR_COUNT: readMux[7:0] = s_reg.count;
      timer8_pkg::ADDR_CMP_A: readMux[7:0] = s_reg.cmpABuf;
      timer8_pkg::ADDR_CMP_B: readMux[7:0] = s_reg.cmpBBuf;
      timer8_pkg::ADDR_FLAGS: begin
        readMux[timer8_pkg::FL_OVF] = s_reg.overflowFlag;
        readMux[timer8_pkg::FL_CMP_A] = s_reg.cmpAFlag;
        readMux[timer8_pkg::FL_CMP_B] = s_reg.cmpBFlag;
      end
      default: readMux = '0;
    endcase
  end

  // next state
  always_comb begin
    s_next = s_reg;
    // one wait state, then answer for one cycle
    s_next.ready = psel && penable && !s_reg.ready;
    s_next.err = psel && penable && !s_reg.ready && !mapped;
    s_next.rdata = (psel && penable && !s_reg.ready && !pwrite) ? readMux : '0;
    // counting sequence
    if (tick) begin
      if (waveClass == timer8_pkg::CLS_PHASE) begin
        if (s_reg.up && atTop) begin
          s_next.up = 1'b0;
          s_next.count = s_reg.count - timer8_pkg::COUNT_STEP;
        end else if (!s_reg.up && s_reg.count == timer8_pkg::COUNT_BOTTOM) begin
          s_next.up = 1'b1;
          s_next.count = s_reg.count + timer8_pkg::COUNT_STEP;
        end else if (s_reg.up) begin
          s_next.count = s_reg.count + timer8_pkg::COUNT_STEP;
        end else begin
          s_next.count = s_reg.count - timer8_pkg::COUNT_STEP;
        end
      end else begin
        s_next.up = 1'b1;
        s_next.count = atTop ? timer8_pkg::COUNT_BOTTOM :
                       s_reg.count + timer8_pkg::COUNT_STEP;
      end
      s_next.blockMatch = 1'b0;
    end
    // compare value update points
    if (waveClass == timer8_pkg::CLS_NONPWM) begin
      s_next.cmpAAct = s_reg.cmpABuf;
      s_next.cmpBAct = s_reg.cmpBBuf;
    end else if (bottomEvt || topEvt) begin
      s_next.cmpAAct = s_reg.cmpABuf;
      s_next.cmpBAct = s_reg.cmpBBuf;
    end
    // register writes
    if (wrCtrlA) begin
      s_next.chanAOutputMode = pwdata[timer8_pkg::CA_OUT_A_LSB +: 2];
      s_next.chanBOutputMode = pwdata[timer8_pkg::CA_OUT_B_LSB +: 2];
      s_next.waveModeLowBits = pwdata[timer8_pkg::CA_WAVE_LSB +: 2];
    end
    if (wrCtrlB) begin
      s_next.waveModeHighBit = pwdata[timer8_pkg::CB_HIGH_BIT];
      s_next.clockSelectField = pwdata[timer8_pkg::CB_CLK_LSB +: 3];
    end
    if (wrCount) begin
      s_next.count = pwdata[7:0];
      s_next.blockMatch = 1'b1;
    end
    if (wrCmpA) begin
      s_next.cmpABuf = pwdata[7:0];
      if (waveClass == timer8_pkg::CLS_NONPWM) begin
        s_next.cmpAAct = pwdata[7:0];
      end
    end
    if (wrCmpB) begin
      s_next.cmpBBuf = pwdata[7:0];
      if (waveClass == timer8_pkg::CLS_NONPWM) begin
        s_next.cmpBAct = pwdata[7:0];
      end
    end
    // sticky flags, write one clears, a new event wins
    s_next.overflowFlag = ovfEvt ||
                          (s_reg.overflowFlag && !(wrFlags && pwdata[timer8_pkg::FL_OVF]));
    s_next.cmpAFlag = matchA || (s_reg.cmpAFlag && !(wrFlags && pwdata[timer8_pkg::FL_CMP_A]));
    s_next.cmpBFlag = matchB || (s_reg.cmpBFlag && !(wrFlags && pwdata[timer8_pkg::FL_CMP_B]));
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.count <= timer8_pkg::RESET_BYTE;
      s_reg.up <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // channel output units
  wave_channel_unit #(.IS_CHAN_B(1'b0)) chanAUnit (
    .ref_clk(ref_clk),
    .rst(rst),
    .outMode(s_reg.chanAOutputMode),
    .highModeBit(s_reg.waveModeHighBit),
    .waveClass(waveClass),
    .match(matchA),
    .bottomEvt(bottomEvt),
    .topEvt(topEvt),
    .upCounting(s_reg.up),
    .compareIsTop(s_reg.cmpAAct == topVal),
    .waveOut(chanAWaveOut),
    .pinOverride(chanAPinOverride)
  );
  wave_channel_unit #(.IS_CHAN_B(1'b1)) chanBUnit (
    .ref_clk(ref_clk),
    .rst(rst),
    .outMode(s_reg.chanBOutputMode),
    .highModeBit(s_reg.waveModeHighBit),
    .waveClass(waveClass),
    .match(matchB),
    .bottomEvt(bottomEvt),
    .topEvt(topEvt),
    .upCounting(s_reg.up),
    .compareIsTop(s_reg.cmpBAct == topVal),
    .waveOut(chanBWaveOut),
    .pinOverride(chanBPinOverride)
  );

  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign countValue = s_reg.count;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence countWrite;
    wrCount && !wrCtrlB;
  endsequence
  sequence nextTick;
    tick && !wrCount;
  endsequence
  a_count_write: assert property (countWrite |=> s_reg.count == $past(pwdata[7:0]))
    else $error("counter write not stored");
  a_match_blocked: assert property (countWrite ##1 nextTick |-> !matchA && !matchB)
    else $error("compare match after counter write");
  a_stop_clock: assert property ((s_reg.clockSelectField == timer8_pkg::CS_STOPPED && !wrCount)
    |=> $stable(s_reg.count))
    else $error("counter moved with no clock");
  a_reserved_zero: assert property ((psel && penable && !pready && !pwrite &&
    addr8 == timer8_pkg::ADDR_CTRL_A) |=> prdata[3:2] == 2'h0)
    else $error("reserved control bits not zero");
  a_ctc_clear: assert property ((waveModeField == timer8_pkg::WM_CTC && tick && atTop &&
    !wrCount && !wrCtrlA && !wrCtrlB) |=> s_reg.count == timer8_pkg::COUNT_BOTTOM)
    else $error("clear-on-match did not clear counter");
  a_phase_turn: assert property ((topEvt && !wrCount) |=> !s_reg.up ##1 !s_reg.up || !tick)
    else $error("phase PWM did not turn at top");
  a_overflow_set: assert property ((ovfEvt && !wrFlags) |=> s_reg.overflowFlag)
    else $error("overflow flag not set");
  a_pin_override: assert property ((s_reg.chanAOutputMode != timer8_pkg::OM_OFF &&
    waveClass == timer8_pkg::CLS_NONPWM) [*2] |-> chanAPinOverride)
    else $error("channel A pin not overridden");
  a_answer_once: assert property (pready |=> !pready)
    else $error("bus answer held too long");
  a_answer_wait: assert property ((psel && penable && !pready) |=> pready)
    else $error("bus answer missing");
endmodule

// ### timer8_pkg.sv
package timer8_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL_A = 8'hB0;
  localparam logic [7:0] ADDR_CTRL_B = 8'hB4;
  localparam logic [7:0] ADDR_COUNT = 8'hB8;
  localparam logic [7:0] ADDR_CMP_A = 8'hBC;
  localparam logic [7:0] ADDR_CMP_B = 8'hC0;
  localparam logic [7:0] ADDR_FLAGS = 8'hC4;
  // control A fields
  localparam int CA_OUT_A_LSB = 6;
  localparam int CA_OUT_B_LSB = 4;
  localparam int CA_WAVE_LSB = 0;
  // control B fields
  localparam int CB_HIGH_BIT = 3;
  localparam int CB_CLK_LSB = 0;
  // flag bits
  localparam int FL_OVF = 0;
  localparam int FL_CMP_A = 1;
  localparam int FL_CMP_B = 2;
  // reset values and limits
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [2:0] CS_STOPPED = 3'h0;
  // wave mode encodings
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PHASE_MAX = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_MAX = 3'h3;
  localparam logic [2:0] WM_PHASE_CMPA = 3'h5;
  localparam logic [2:0] WM_FAST_CMPA = 3'h7;
  // output mode encodings
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  typedef enum logic [1:0] {CLS_NONPWM, CLS_FAST, CLS_PHASE} wave_class_t;
endpackage

// ### wave_channel_unit.sv
`timescale 1ns/1ps
module wave_channel_unit #(
  parameter bit IS_CHAN_B = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] outMode,
  input wire logic highModeBit,
  input wire timer8_pkg::wave_class_t waveClass,
  input wire logic match,
  input wire logic bottomEvt,
  input wire logic topEvt,
  input wire logic upCounting,
  input wire logic compareIsTop,
  output logic waveOut,
  output logic pinOverride
);
  typedef struct packed {
    logic level;
    logic drive;
  } chan_state_t;
  chan_state_t s_reg;
  chan_state_t s_next;
  logic toggleOk;

  // pin override and output action per wave class
  always_comb begin
    s_next = s_reg;
    toggleOk = (outMode == timer8_pkg::OM_TOGGLE) &&
               ((waveClass == timer8_pkg::CLS_NONPWM) || (!IS_CHAN_B && highModeBit));
    s_next.drive = (outMode != timer8_pkg::OM_OFF) &&
                   !((waveClass != timer8_pkg::CLS_NONPWM) &&
                     (outMode == timer8_pkg::OM_TOGGLE) && (IS_CHAN_B || !highModeBit));
    unique case (waveClass)
      timer8_pkg::CLS_NONPWM: begin
        if (match) begin
          unique case (outMode)
            timer8_pkg::OM_OFF: s_next.level = s_reg.level;
            timer8_pkg::OM_TOGGLE: s_next.level = !s_reg.level;
            timer8_pkg::OM_CLEAR: s_next.level = 1'b0;
            timer8_pkg::OM_SET: s_next.level = 1'b1;
          endcase
        end
      end
      timer8_pkg::CLS_FAST: begin
        if (match && toggleOk) begin
          s_next.level = !s_reg.level;
        end else if (outMode[1]) begin
          if (match && !compareIsTop) begin
            s_next.level = outMode[0];
          end else if (bottomEvt) begin
            s_next.level = !outMode[0];
          end
        end
      end
      timer8_pkg::CLS_PHASE: begin
        if (match && toggleOk) begin
          s_next.level = !s_reg.level;
        end else if (outMode[1]) begin
          if (match && !compareIsTop) begin
            s_next.level = upCounting ? outMode[0] : !outMode[0];
          end else if (topEvt && compareIsTop) begin
            s_next.level = !outMode[0];
          end
        end
      end
      default: s_next = s_reg;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign waveOut = s_reg.level;
  assign pinOverride = s_reg.drive;

  // inverting fast PWM ends up low after a bottom event with no match
  a_fast_bottom: assert property (@(posedge ref_clk) disable iff (rst)
    (waveClass == timer8_pkg::CLS_FAST && outMode == timer8_pkg::OM_SET && bottomEvt
     && !match) |=> !waveOut)
    else $error("fast PWM inverting output not cleared at bottom");
endmodule

// ### timer8_waveform_output_control_test.sv
`timescale 1ns/1ps
module timer8_waveform_output_control_test;
  logic ref_clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] countValue;
  logic chanAWaveOut;
  logic chanAPinOverride;
  logic chanBWaveOut;
  logic chanBPinOverride;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] rdata;
  logic rerr;
  logic [1:0] om;
  logic [2:0] wm;
  logic [7:0] held;

  timer8_waveform_output_control uut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .countValue(countValue), .chanAWaveOut(chanAWaveOut),
    .chanAPinOverride(chanAPinOverride), .chanBWaveOut(chanBWaveOut),
    .chanBPinOverride(chanBPinOverride)
  );

  // clock source
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // verdict and end of run
  task results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      results();
    end
  end

  // compare seen against expected
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready wait", 32'h0, 32'h1);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, rdata, rerr);
  endtask

  // wait for a count value, bounded
  task waitCount(input logic [7:0] v);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (countValue !== v && n < 1000);
    if (n >= 1000) begin
      chk("count wait", {24'h0, countValue}, {24'h0, v});
    end
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, reserved bits, unmapped place
    rd(timer8_pkg::ADDR_CTRL_A);
    chk("ctrl a reset", rdata, 32'h0);
    chk("pin a reset", {31'h0, chanAPinOverride}, 32'h0);
    wr(timer8_pkg::ADDR_CTRL_A, 32'hFF);
    rd(timer8_pkg::ADDR_CTRL_A);
    chk("ctrl a reserved", rdata, 32'hF3);
    rd(8'hC8);
    chk("unmapped data", rdata, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    wr(timer8_pkg::ADDR_CTRL_B, 32'h00);
    wr(timer8_pkg::ADDR_CTRL_A, 32'h53);
    // override flop follows the mode register one cycle later
    @(posedge ref_clk);
    #1;
    chk("fast 01 pin a", {31'h0, chanAPinOverride}, 32'h0);
    chk("fast 01 pin b", {31'h0, chanBPinOverride}, 32'h0);
    wr(timer8_pkg::ADDR_CTRL_B, 32'h08);
    @(posedge ref_clk);
    #1;
    chk("fast 01 high pin a", {31'h0, chanAPinOverride}, 32'h1);
    chk("fast 01 high pin b", {31'h0, chanBPinOverride}, 32'h0);
    $display("test modes and registers done");
    // non-pwm set, clear, toggle on both channels
    wr(timer8_pkg::ADDR_CTRL_B, 32'h00);
    wr(timer8_pkg::ADDR_CMP_A, 32'h10);
    wr(timer8_pkg::ADDR_CMP_B, 32'h10);
    for (int i = 0; i < 3; i++) begin
      om = 2'(3 - i);
      wr(timer8_pkg::ADDR_CTRL_B, 32'h00);
      // let the last tick of the stop edge settle before sampling
      #1;
      held = countValue;
      repeat (8) @(posedge ref_clk);
      #1;
      chk("stopped count", {24'h0, countValue}, {24'h0, held});
      wr(timer8_pkg::ADDR_COUNT, 32'h0E);
      wr(timer8_pkg::ADDR_CTRL_A, {24'h0, om, om, 4'h0});
      wr(timer8_pkg::ADDR_CTRL_B, 32'h01);
      waitCount(8'h12);
      // pin direction stays with software outside; override only claims the pin
      chk("pin a owned", {31'h0, chanAPinOverride}, 32'h1);
      chk("pin b owned", {31'h0, chanBPinOverride}, 32'h1);
      chk("non-pwm a", {31'h0, chanAWaveOut}, {31'h0, i != 1});
      chk("non-pwm b", {31'h0, chanBWaveOut}, {31'h0, i != 1});
    end
    $display("test non-pwm outputs done");
    // fast pwm, a non-inverting and b inverting
    wr(timer8_pkg::ADDR_CTRL_B, 32'h00);
    wr(timer8_pkg::ADDR_CMP_A, 32'h40);
    wr(timer8_pkg::ADDR_CMP_B, 32'h80);
    wr(timer8_pkg::ADDR_CTRL_A, 32'hB3);
    wr(timer8_pkg::ADDR_CTRL_B, 32'h01);
    waitCount(8'h02);
    waitCount(8'h42);
    chk("fast a match", {31'h0, chanAWaveOut}, 32'h0);
    waitCount(8'h82);
    chk("fast b match", {31'h0, chanBWaveOut}, 32'h1);
    waitCount(8'h02);
    chk("fast a bottom", {31'h0, chanAWaveOut}, 32'h1);
    chk("fast b bottom", {31'h0, chanBWaveOut}, 32'h0);
    wr(timer8_pkg::ADDR_CMP_A, 32'hFF);
    waitCount(8'h02);
    waitCount(8'h02);
    chk("fast a at top", {31'h0, chanAWaveOut}, 32'h1);
    $display("test fast pwm done");
    // phase pwm, direction dependent actions and overflow at bottom
    wr(timer8_pkg::ADDR_CTRL_A, 32'h81);
    wr(timer8_pkg::ADDR_CMP_A, 32'h40);
    waitCount(8'hFF);
    wr(timer8_pkg::ADDR_FLAGS, 32'h07);
    rd(timer8_pkg::ADDR_FLAGS);
    chk("ovf cleared", {31'h0, rdata[timer8_pkg::FL_OVF]}, 32'h0);
    waitCount(8'h3E);
    chk("phase a down", {31'h0, chanAWaveOut}, 32'h1);
    waitCount(8'h42);
    chk("phase a up", {31'h0, chanAWaveOut}, 32'h0);
    rd(timer8_pkg::ADDR_FLAGS);
    chk("ovf at bottom", {31'h0, rdata[timer8_pkg::FL_OVF]}, 32'h1);
    $display("test phase pwm done");
    // compare a as top in modes 5, 7 and 2
    for (int i = 0; i < 3; i++) begin
      wm = (i == 0) ? 3'h5 : ((i == 1) ? 3'h7 : 3'h2);
      wr(timer8_pkg::ADDR_CTRL_B, 32'h00);
      wr(timer8_pkg::ADDR_CTRL_A, {30'h0, wm[1:0]});
      wr(timer8_pkg::ADDR_COUNT, 32'h00);
      wr(timer8_pkg::ADDR_CTRL_B, {28'h0, wm[2], 3'h1});
      waitCount(8'h40);
      @(posedge ref_clk);
      #1;
      chk("after top", {24'h0, countValue}, (i == 0) ? 32'h3F : 32'h0);
    end
    $display("test top source done");
    results();
  end
endmodule
